// File: hdl/pswdrv_top.sv
// Power switch driver protection and converter control logic
`timescale 1ns/1ns
module pswdrv_top
   import pswdrv_pkg::*;
#(
   parameter int SHORT_RESET_CYCLES = SHORT_RESET_CYC,
   parameter int PERIOD_WIDTH = 16
)
(
   input wire logic clock,
   input wire logic srst,
   input wire logic gate_cmd,
   input wire pswdrv_sense_s sense,
   input wire logic drive_pin_open,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic gate_on,
   output logic gate_slow_off,
   output logic converter_peak_limit_high,
   output logic converter_switch_node,
   output logic aux_five_volt_rail,
   output logic negative_gate_rail,
   output logic fault_indicator_n,
   output logic current_limit_indicator_n
);
   // ==========================================================
   // Declarations
   logic [31:0] ctrl_reg;
   logic [PERIOD_WIDTH-1:0] period_th_reg;
   logic cmd_prev_reg;
   logic [PERIOD_WIDTH-1:0] period_cnt_reg;
   logic [2:0] fast_cnt_reg;
   logic limit_high_reg;
   logic [7:0] trip_dly_reg;
   logic cycle_limit_reg;
   logic short_reg;
   logic [31:0] low_cnt_reg;
   logic aux_on_reg;
   logic startup_reg;
   pswdrv_cnv_e cnv_reg;
   pswdrv_cnv_e cnv_next;
   logic cmd_rise;
   logic delayed_trip;
   logic driver_hot;
   logic switch_hot;
   logic lockout;
   logic gate_next;
   logic acc;

   assign cmd_rise = gate_cmd & ~cmd_prev_reg;
   assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign driver_hot = sense.driver_hot;
   assign switch_hot = sense.switch_hot;
   assign lockout = sense.supply_low | ~aux_on_reg;

   // ==========================================================
   // Wishbone slave
   // Ack one cycle after strobe, drop after
   always_ff @(posedge clock)
   begin
      if (srst)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= acc;
   end

   // Control and config writes
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         ctrl_reg <= CTRL_RESET_VAL;
         period_th_reg <= PERIOD_WIDTH'(CFG_PERIOD_RESET);
      end
      else if (acc && wb_we_i)
      begin
         if (wb_adr_i == PSW_CTRL_ADDR && wb_sel_i[0])
            ctrl_reg[7:0] <= wb_dat_i[7:0];
         if (wb_adr_i == PSW_CFG_ADDR && wb_sel_i[0])
            period_th_reg[7:0] <= wb_dat_i[7:0];
         if (wb_adr_i == PSW_CFG_ADDR && wb_sel_i[1])
            period_th_reg[PERIOD_WIDTH-1:8] <= wb_dat_i[PERIOD_WIDTH-1:8];
      end
   end

   // Read data, unmapped reads as zero
   always_ff @(posedge clock)
   begin
      if (srst)
         wb_dat_o <= 32'h0000_0000;
      else if (acc)
      begin
         wb_dat_o <= 32'h0000_0000;
         case (wb_adr_i)
            PSW_CTRL_ADDR: wb_dat_o <= ctrl_reg;
            PSW_CFG_ADDR: wb_dat_o <= 32'(period_th_reg);
            PSW_STAT_ADDR:
            begin
               wb_dat_o[STAT_LIMIT_HIGH_BIT] <= limit_high_reg;
               wb_dat_o[STAT_CURRENT_BIT] <= cycle_limit_reg;
               wb_dat_o[STAT_SHORT_BIT] <= short_reg;
               wb_dat_o[STAT_SWITCH_TEMP_BIT] <= switch_hot;
               wb_dat_o[STAT_DRIVER_TEMP_BIT] <= driver_hot;
               wb_dat_o[STAT_UNDERVOLT_BIT] <= sense.supply_low;
               wb_dat_o[STAT_AUX_ON_BIT] <= aux_on_reg;
               wb_dat_o[STAT_GATE_BIT] <= gate_on;
               wb_dat_o[STAT_SLOW_BIT] <= gate_slow_off;
               wb_dat_o[STAT_CCM_BIT] <= startup_reg;
            end
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Frequency detector
   // Period counter between command rising edges
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         cmd_prev_reg <= 1'b0;
         // Saturated: first rise after reset has no period, counts slow
         period_cnt_reg <= '1;
      end
      else
      begin
         cmd_prev_reg <= gate_cmd;
         if (cmd_rise)
            period_cnt_reg <= '0;
         else if (period_cnt_reg != '1)
            period_cnt_reg <= period_cnt_reg + 1'b1;
      end
   end

   // Five fast periods in a row latch the high limit
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         fast_cnt_reg <= 3'h0;
         limit_high_reg <= 1'b0;
      end
      else if (cmd_rise && !limit_high_reg)
      begin
         if (period_cnt_reg < period_th_reg)
         begin
            fast_cnt_reg <= fast_cnt_reg + 3'h1;
            if (fast_cnt_reg == 3'(HIGH_FREQ_CYCLES - 1))
               limit_high_reg <= 1'b1;
         end
         else
            fast_cnt_reg <= 3'h0;
      end
   end

   // ==========================================================
   // Current protection
   // Delayed trip signal; race against undelayed short flag
   always_ff @(posedge clock)
   begin
      if (srst || !sense.current_trip)
         trip_dly_reg <= 8'h00;
      else if (trip_dly_reg != 8'(TRIP_DELAY_CYC))
         trip_dly_reg <= trip_dly_reg + 8'h01;
   end
   assign delayed_trip = trip_dly_reg == 8'(TRIP_DELAY_CYC);

   // Cycle limiter cleared by command low
   always_ff @(posedge clock)
   begin
      if (srst || !gate_cmd)
         cycle_limit_reg <= 1'b0;
      else if (delayed_trip && !short_reg && !sense.short_trip && gate_on)
         cycle_limit_reg <= 1'b1;
   end

   // Short latch and its low-command reset timer
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         short_reg <= 1'b0;
         low_cnt_reg <= '0;
      end
      else
      begin
         if (gate_cmd)
            low_cnt_reg <= '0;
         else if (low_cnt_reg != 32'(SHORT_RESET_CYCLES))
            low_cnt_reg <= low_cnt_reg + 32'h1;
         if (sense.short_trip && !cycle_limit_reg && gate_on)
            short_reg <= 1'b1;
         else if (low_cnt_reg == 32'(SHORT_RESET_CYCLES))
            short_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Supply, thermal and gate control
   // Aux rail and converter enable
   always_ff @(posedge clock)
   begin
      if (srst)
         aux_on_reg <= 1'b0;
      else if (sense.supply_low || driver_hot)
         aux_on_reg <= 1'b0;
      else if (sense.supply_ok && ctrl_reg[CTRL_ENABLE_BIT])
         aux_on_reg <= 1'b1;
   end

   // Gate decision by priority
   always_comb
   begin
      gate_next = 1'b0;
      if (lockout || driver_hot)
         gate_next = 1'b0;
      else if (drive_pin_open || short_reg)
         gate_next = 1'b0;
      else if (switch_hot)
         gate_next = sense.reverse_current;
      else
         gate_next = gate_cmd && !cycle_limit_reg;
   end

   // Gate and slow turn-off drive
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         gate_on <= 1'b0;
         gate_slow_off <= 1'b0;
      end
      else
      begin
         gate_on <= gate_next;
         gate_slow_off <= short_reg;
      end
   end

   // Indicators
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         fault_indicator_n <= 1'b1;
         current_limit_indicator_n <= 1'b1;
      end
      else
      begin
         fault_indicator_n <= !(lockout || switch_hot || driver_hot ||
            drive_pin_open || short_reg);
         current_limit_indicator_n <= !(cycle_limit_reg || short_reg);
      end
   end

   // ==========================================================
   // Converter hysteretic control
   always_comb
   begin
      cnv_next = cnv_reg;
      case (cnv_reg)
         CNV_OFF: if (aux_on_reg) cnv_next = CNV_IDLE;
         CNV_IDLE: if (!sense.rail_ok) cnv_next = CNV_RAMP;
         CNV_RAMP: if (sense.peak_reached) cnv_next = CNV_FALL;
         CNV_FALL:
            if (sense.ind_zero)
               cnv_next = sense.rail_ok ? CNV_IDLE : CNV_RAMP;
            else if (startup_reg && !sense.rail_ok)
               cnv_next = CNV_RAMP;
         default: cnv_next = CNV_OFF;
      endcase
      if (!aux_on_reg)
         cnv_next = CNV_OFF;
   end

   // Converter state and start-up phase
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         cnv_reg <= CNV_OFF;
         startup_reg <= 1'b1;
      end
      else
      begin
         cnv_reg <= cnv_next;
         if (!aux_on_reg)
            startup_reg <= 1'b1;
         else if (sense.rail_ok)
            startup_reg <= 1'b0;
      end
   end

   // Converter outputs
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         converter_switch_node <= 1'b0;
         aux_five_volt_rail <= 1'b0;
         negative_gate_rail <= 1'b0;
         converter_peak_limit_high <= 1'b0;
      end
      else
      begin
         converter_switch_node <= cnv_next == CNV_RAMP;
         aux_five_volt_rail <= aux_on_reg;
         negative_gate_rail <= aux_on_reg;
         converter_peak_limit_high <= limit_high_reg;
      end
   end

   // ==========================================================
   // Checks
   chk_limit_sticky: assert property (@(posedge clock) disable iff (srst)
      limit_high_reg |=> limit_high_reg)
      else $error("peak limit dropped");
   chk_short_holds: assert property (@(posedge clock) disable iff (srst)
      short_reg |=> !gate_on)
      else $error("gate on while short latched");
   chk_driver_hot_off: assert property (@(posedge clock) disable iff (srst)
      driver_hot |=> !gate_on ##1 !aux_five_volt_rail)
      else $error("driver hot not shut down");
   chk_undervolt_flag: assert property (@(posedge clock) disable iff (srst)
      sense.supply_low |=> !fault_indicator_n && !gate_on)
      else $error("undervoltage not flagged");
   chk_thermal_flag: assert property (@(posedge clock) disable iff (srst)
      (switch_hot || driver_hot) |=> !fault_indicator_n)
      else $error("thermal not flagged");
   chk_limit_clears: assert property (@(posedge clock) disable iff (srst)
      !gate_cmd |=> !cycle_limit_reg)
      else $error("current limit not cleared");
   chk_limit_blocks: assert property (@(posedge clock) disable iff (srst)
      cycle_limit_reg |=> !gate_on)
      else $error("gate on during current limit");
   chk_short_slow: assert property (@(posedge clock) disable iff (srst)
      $rose(short_reg) |=> gate_slow_off && !current_limit_indicator_n)
      else $error("short not slowed");
   chk_ramp_ends: assert property (@(posedge clock) disable iff (srst)
      cnv_reg == CNV_RAMP && sense.peak_reached && aux_on_reg |=>
      !converter_switch_node)
      else $error("ramp not ended at peak");
   chk_short_flags: assert property (@(posedge clock) disable iff (srst)
      short_reg |=> !fault_indicator_n && !current_limit_indicator_n)
      else $error("short not on both indicators");
endmodule : pswdrv_top

// File: hdl/pswdrv_pkg.sv
// Package: constants, states and carriers of the power switch driver logic
package pswdrv_pkg;
   // ==========================================================
   // Register map (word byte addresses)
   localparam logic [7:0] PSW_CTRL_ADDR = 8'h00;
   localparam logic [7:0] PSW_STAT_ADDR = 8'h04;
   localparam logic [7:0] PSW_CFG_ADDR = 8'h08;
   // Control fields
   localparam int CTRL_ENABLE_BIT = 0;
   localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0001;
   // Status fields
   localparam int STAT_LIMIT_HIGH_BIT = 0;
   localparam int STAT_CURRENT_BIT = 1;
   localparam int STAT_SHORT_BIT = 2;
   localparam int STAT_SWITCH_TEMP_BIT = 3;
   localparam int STAT_DRIVER_TEMP_BIT = 4;
   localparam int STAT_UNDERVOLT_BIT = 5;
   localparam int STAT_AUX_ON_BIT = 6;
   localparam int STAT_GATE_BIT = 7;
   localparam int STAT_SLOW_BIT = 8;
   localparam int STAT_CCM_BIT = 9;
   // Config: period threshold in clock cycles (higher range below it)
   localparam logic [15:0] CFG_PERIOD_RESET = 16'h0032;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int SHORT_RESET_US = 200;
   localparam int SHORT_RESET_CYC = SHORT_RESET_US * CLK_MHZ;
   localparam int HIGH_FREQ_CYCLES = 5;
   localparam int TRIP_DELAY_NS = 50;
   localparam int TRIP_DELAY_CYC = (TRIP_DELAY_NS * CLK_MHZ + 999) / 1000;
   // ==========================================================
   // Converter phase states, one-hot
   typedef enum logic [3:0]
   {
      CNV_IDLE = 4'b0001,
      CNV_RAMP = 4'b0010,
      CNV_FALL = 4'b0100,
      CNV_OFF = 4'b1000
   } pswdrv_cnv_e;
   // Sensor flags carried together
   typedef struct packed
   {
      logic current_trip;
      logic short_trip;
      logic switch_hot;
      logic driver_hot;
      logic supply_ok;
      logic supply_low;
      logic peak_reached;
      logic ind_zero;
      logic rail_ok;
      logic reverse_current;
   } pswdrv_sense_s;
endpackage : pswdrv_pkg

// File: testbench/pswdrv_pwm_model.sv
// Model of the external PWM controller that feeds the gate command
`timescale 1ns/1ns
module pswdrv_pwm_model
#(
   parameter int MIN_PERIOD = 46
)
(
   input wire logic clock,
   input wire logic run,
   input wire logic level,
   input wire logic [7:0] period,
   output logic gate_cmd
);
   logic [7:0] cnt_reg;
   logic [7:0] per_t;
   // ==========================================
   // Command generation
   // Period clamped so the rate never passes the supported maximum
   assign per_t = (period < 8'(MIN_PERIOD)) ? 8'(MIN_PERIOD) : period;
   // Phase counter, restarts from a rising edge at each run
   always_ff @(posedge clock)
   begin
      if (!run || cnt_reg >= per_t - 8'h01)
         cnt_reg <= 8'h00;
      else
         cnt_reg <= cnt_reg + 8'h01;
   end
   // Half duty while running, else a static level (long low clears a latch)
   assign gate_cmd = run ? (cnt_reg < (per_t >> 1)) : level;
endmodule : pswdrv_pwm_model

// File: testbench/pswdrv_top_tb.sv
// Self-checking bench of the power switch driver protection logic
`timescale 1ns/1ns
module pswdrv_top_tb;
   import pswdrv_pkg::*;
   localparam int SRC = 20;
   logic clock, srst, gate_cmd, drive_pin_open, run, level;
   logic [7:0] period;
   pswdrv_sense_s sense;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic gate_on, gate_slow_off, converter_peak_limit_high;
   logic converter_switch_node, aux_five_volt_rail, negative_gate_rail;
   logic fault_indicator_n, current_limit_indicator_n;
   int n_errors = 0;
   int cmp_count = 0;
   // ==========================================
   // Instances
   pswdrv_top #(.SHORT_RESET_CYCLES(SRC)) i_dut (.clock(clock),
      .srst(srst), .gate_cmd(gate_cmd), .sense(sense),
      .drive_pin_open(drive_pin_open), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .gate_on(gate_on), .gate_slow_off(gate_slow_off),
      .converter_peak_limit_high(converter_peak_limit_high),
      .converter_switch_node(converter_switch_node),
      .aux_five_volt_rail(aux_five_volt_rail),
      .negative_gate_rail(negative_gate_rail),
      .fault_indicator_n(fault_indicator_n),
      .current_limit_indicator_n(current_limit_indicator_n));
   pswdrv_pwm_model i_pwm (.clock(clock), .run(run), .level(level),
      .period(period), .gate_cmd(gate_cmd));
   // ==========================================
   // Helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : cyc
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   // Classic single Wishbone cycle, held until ack is seen
   task automatic wb(input logic we, input logic [7:0] adr,
      input logic [31:0] dat, output logic [31:0] q);
      int i;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_sel_i <= 4'hF;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      i = 0;
      do
      begin
         @(posedge clock);
         i++;
      end
      while (wb_ack_o !== 1'b1 && i < 50);
      q = wb_dat_o;
      chk(wb_ack_o, 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clock);
   endtask : wb
   task automatic final_report;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   // ==========================================
   // Scenarios
   task automatic t_supply;
      chk(converter_peak_limit_high, 1'b0);
      chk(current_limit_indicator_n, 1'b1);
      chk(gate_on, 1'b0);
      chk(fault_indicator_n, 1'b0);
      chk(aux_five_volt_rail, 1'b0);
      sense.supply_low <= 1'b0;
      sense.supply_ok <= 1'b1;
      cyc(4);
      chk({aux_five_volt_rail, negative_gate_rail}, 2'h3);
      chk({gate_on, fault_indicator_n}, 2'h3);
      sense.supply_low <= 1'b1;
      sense.supply_ok <= 1'b0;
      cyc(4);
      chk({aux_five_volt_rail, negative_gate_rail}, 2'h0);
      chk({gate_on, fault_indicator_n}, 2'h0);
      sense.supply_low <= 1'b0;
      sense.supply_ok <= 1'b1;
      level <= 1'b0;
      cyc(4);
      chk(aux_five_volt_rail, 1'b1);
   endtask : t_supply
   task automatic t_freq;
      level <= 1'b0;
      cyc(60);
      run <= 1'b1;
      cyc(5 * 46 - 12);
      run <= 1'b0;
      cyc(4);
      chk(converter_peak_limit_high, 1'b0);
      run <= 1'b1;
      cyc(10 * 46);
      run <= 1'b0;
      cyc(4);
      chk(converter_peak_limit_high, 1'b1);
      period <= 8'h64;
      run <= 1'b1;
      cyc(400);
      run <= 1'b0;
      cyc(4);
      chk(converter_peak_limit_high, 1'b1);
   endtask : t_freq
   task automatic t_regs;
      wb(1'b0, PSW_CTRL_ADDR, 32'h0, rd);
      chk(rd, CTRL_RESET_VAL);
      wb(1'b0, PSW_CFG_ADDR, 32'h0, rd);
      chk(rd, 32'(CFG_PERIOD_RESET));
      wb(1'b1, PSW_CFG_ADDR, 32'h0000_0040, rd);
      wb(1'b0, PSW_CFG_ADDR, 32'h0, rd);
      chk(rd, 32'h0000_0040);
      wb(1'b1, PSW_CFG_ADDR, 32'(CFG_PERIOD_RESET), rd);
      wb(1'b1, 8'h10, 32'hFFFF_FFFF, rd);
      wb(1'b0, 8'h10, 32'h0, rd);
      chk(rd, 32'h0);
      wb(1'b1, PSW_STAT_ADDR, 32'h0, rd);
      wb(1'b0, PSW_STAT_ADDR, 32'h0, rd);
      chk(rd[STAT_LIMIT_HIGH_BIT], 1'b1);
   endtask : t_regs
   task automatic t_ovc;
      level <= 1'b1;
      cyc(3);
      chk(gate_on, 1'b1);
      sense.current_trip <= 1'b1;
      cyc(6);
      sense.short_trip <= 1'b1;
      cyc(3);
      chk({gate_on, gate_slow_off}, 2'h0);
      chk({fault_indicator_n, current_limit_indicator_n}, 2'h2);
      sense.current_trip <= 1'b0;
      sense.short_trip <= 1'b0;
      level <= 1'b0;
      cyc(3);
      chk(current_limit_indicator_n, 1'b1);
      level <= 1'b1;
      cyc(3);
      chk(gate_on, 1'b1);
   endtask : t_ovc
   task automatic t_short;
      sense.current_trip <= 1'b1;
      sense.short_trip <= 1'b1;
      cyc(3);
      chk({gate_on, gate_slow_off}, 2'h1);
      chk({fault_indicator_n, current_limit_indicator_n}, 2'h0);
      sense.current_trip <= 1'b0;
      sense.short_trip <= 1'b0;
      level <= 1'b0;
      cyc(5);
      level <= 1'b1;
      cyc(3);
      chk(gate_on, 1'b0);
      level <= 1'b0;
      cyc(SRC + 4);
      level <= 1'b1;
      cyc(3);
      chk({gate_on, fault_indicator_n}, 2'h3);
   endtask : t_short
   task automatic t_thermal;
      sense.switch_hot <= 1'b1;
      cyc(3);
      chk({gate_on, fault_indicator_n}, 2'h0);
      sense.reverse_current <= 1'b1;
      cyc(3);
      chk({gate_on, fault_indicator_n}, 2'h2);
      sense.driver_hot <= 1'b1;
      cyc(3);
      chk({gate_on, aux_five_volt_rail, negative_gate_rail}, 3'h0);
      chk(fault_indicator_n, 1'b0);
      sense.driver_hot <= 1'b0;
      cyc(3);
      chk({gate_on, fault_indicator_n}, 2'h2);
      sense.switch_hot <= 1'b0;
      sense.reverse_current <= 1'b0;
      cyc(3);
      chk({gate_on, fault_indicator_n}, 2'h3);
      drive_pin_open <= 1'b1;
      cyc(3);
      chk({fault_indicator_n, current_limit_indicator_n}, 2'h1);
      drive_pin_open <= 1'b0;
   endtask : t_thermal
   task automatic t_conv;
      chk(converter_switch_node, 1'b1);
      sense.peak_reached <= 1'b1;
      cyc(1);
      sense.peak_reached <= 1'b0;
      cyc(1);
      chk(converter_switch_node, 1'b0);
      cyc(1);
      chk(converter_switch_node, 1'b1);
      sense.rail_ok <= 1'b1;
      cyc(2);
      sense.peak_reached <= 1'b1;
      cyc(1);
      sense.peak_reached <= 1'b0;
      cyc(2);
      chk(converter_switch_node, 1'b0);
      sense.ind_zero <= 1'b1;
      cyc(2);
      chk(converter_switch_node, 1'b0);
      sense.rail_ok <= 1'b0;
      sense.ind_zero <= 1'b0;
      cyc(2);
      chk(converter_switch_node, 1'b1);
   endtask : t_conv
   // ==========================================
   // Clock, watchdog and main sequence
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial
   begin
      cyc(5000);
      n_errors++;
      final_report;
   end
   initial
   begin
      srst = 1'b1;
      sense = '0;
      sense.supply_low = 1'b1;
      drive_pin_open = 1'b0;
      run = 1'b0;
      level = 1'b1;
      period = 8'h2E;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      cyc(10);
      srst <= 1'b0;
      cyc(3);
      t_supply;
      t_freq;
      t_regs;
      t_ovc;
      t_short;
      t_thermal;
      t_conv;
      final_report;
   end
endmodule : pswdrv_top_tb
